/* File: sfhps_core.sv */
/*
 * Serial flash control logic: pause function, status register with its
 * write lock, write-enable latch and the busy timer of internal operations.
 * Assumes an SPI host on the serial pins (mode 0 or 3) and APB software
 * that observes and steers the block. The array itself is outside.
 */
// Our own choices: the APB register port and the register offsets.
// What this block does
// - Pause falls with clock low: paused.
// - Pause falls with clock high: wait low.
// - Pause rises with clock low: resume.
// - Pause rises with clock high: wait low.
// - Paused: output floats, inputs ignored, state kept.
// - Chip select high while paused resets interface.
// - Status write refused when pin low, lock set.
// - Status reads answered while busy.
// - Bit 0 is busy, read-only.
// - Bit 1 is latch; clear refuses program and erase.
// - Bits 2 to 4 protection, reset ones.
// - Bit 5 reserved, reads zero.
// - Bit 6 shows auto-increment mode.
// - Bit 7 lock freezes protection bits while pin low.
// - Status write sets protection and lock, clears latch.
// - Status bits volatile, reset defaults.
// - Latch cleared on listed events.
// - Protection level selects protected upper region.
// - Chip erase only with protection zero.
`timescale 1ns/100ps
`default_nettype none
`include "sfhps_consts.svh"

module sfhps_core
    import sfhps_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link pins.
    input wire logic chip_sel_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic pause_n,
    input wire logic wprot_n,
    output logic sdo,
    output logic sdo_oe,
    // Protected region start block, 16 means nothing protected.
    output logic [4:0] protect_from_block
);

    // Synchronised pins and their previous values.
    sfhps_link_type pins;
    sfhps_link_type lk;
    sfhps_link_type lk_d;
    // Status register and decoder state.
    sfhps_status_type status;
    sfhps_phase_type phase;
    logic paused;
    logic [7:0] shifter;
    logic [2:0] bit_cnt;
    logic [7:0] opcode;
    logic [7:0] out_byte;
    logic [2:0] arg_bytes;
    // Internal operation timer and software controls.
    logic [15:0] op_len;
    logic [15:0] op_timer;
    logic op_clears_wel;
    logic top_reached;
    logic [7:0] cmd_count;

    assign pins = '{chip_sel_n, sclk, sdi, pause_n, wprot_n};

    // Pins cross into pclk through two flip-flops.
    sfhps_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pins),
        .synced(lk)
    );

    // Edge detection works on the second stage only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_d <= `SFHPS_LINK_IDLE;
        end else begin
            lk_d <= lk;
        end
    end

    // Returns the start block of the protected region for a level.
    function automatic logic [4:0] region_start(input logic [2:0] lvl);
        logic [4:0] r;
        r = 5'h10;
        unique case (lvl)
            3'h0: r = 5'h10;
            3'h1: r = 5'h0F;
            3'h2: r = 5'h0E;
            3'h3: r = 5'h0C;
            3'h4: r = 5'h08;
            default: r = 5'h00;
        endcase
        return r;
    endfunction : region_start

    // Pause state follows the pause pin, sampled only while clock is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            paused <= 1'b0;
        end else if (lk.chip_sel_n) begin
            // Select gates pause.
            // Outside a frame there is no pause to hold.
            paused <= 1'b0;
        end else if (!lk.sclk) begin
            paused <= !lk.pause_n;
        end
    end

    // Rising and falling serial clock edges that the decoder may use.
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    assign sck_rise = lk.sclk && !lk_d.sclk && !paused && !lk.chip_sel_n;
    assign sck_fall = !lk.sclk && lk_d.sclk && !paused && !lk.chip_sel_n;
    assign frame_end = lk.chip_sel_n && !lk_d.chip_sel_n;

    // Command opcode valid once eight bits are in.
    logic busy_now;
    logic wel_ok;
    logic status_wr_ok;
    assign busy_now = status.busy;
    assign wel_ok = status.write_enable_latch && !busy_now;
    assign status_wr_ok = wprot_ok(lk.wprot_n, status.lock);

    // Status writes are allowed unless the pin is low and lock is set.
    function automatic logic wprot_ok(input logic pin, input logic lk_bit);
        return pin || !lk_bit;
    endfunction : wprot_ok

    // Serial decoder: shifts bits in on rising clock, acts at frame end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= SFHPS_IDLE;
            shifter <= 8'h00;
            bit_cnt <= 3'h0;
            opcode <= 8'h00;
            arg_bytes <= 3'h0;
        end else if (frame_end) begin
            phase <= SFHPS_IDLE;
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            shifter <= {shifter[6:0], lk.sdi};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                unique case (phase)
                    SFHPS_IDLE, SFHPS_OPCODE: begin
                        opcode <= {shifter[6:0], lk.sdi};
                        phase <= SFHPS_ARGS;
                        arg_bytes <= 3'h0;
                    end
                    SFHPS_ARGS: begin
                        arg_bytes <= arg_bytes + 3'h1;
                        shifter <= {shifter[6:0], lk.sdi};
                    end
                    SFHPS_DONE: begin
                        phase <= SFHPS_DONE;
                    end
                endcase
            end
        end else if (!lk.chip_sel_n && phase == SFHPS_IDLE) begin
            phase <= SFHPS_OPCODE;
        end
    end

    // Last full data byte received, used by status writes.
    logic [7:0] last_byte;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_byte <= 8'h00;
        end else if (sck_rise && bit_cnt == 3'h7 && phase == SFHPS_ARGS) begin
            last_byte <= {shifter[6:0], lk.sdi};
        end
    end

    // Commands complete when select rises after whole bytes.
    logic cmd_ok;
    assign cmd_ok = frame_end && phase == SFHPS_ARGS && bit_cnt == 3'h0
        && !paused;

    // Status register and operation timer.
    // A frame end while paused is an abandon, so it starts nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `SFHPS_STATUS_RESET;
            op_timer <= 16'h0000;
            op_clears_wel <= 1'b0;
        end else begin
            if (status.busy) begin
                if (op_timer <= 16'h0001) begin
                    status.busy <= 1'b0;
                    op_timer <= 16'h0000;
                    if (op_clears_wel) begin
                        status.write_enable_latch <= 1'b0;
                    end
                    if (status.auto_increment_program && top_reached) begin
                        status.auto_increment_program <= 1'b0;
                        status.write_enable_latch <= 1'b0;
                    end
                end else begin
                    op_timer <= op_timer - 16'h0001;
                end
            end else if (cmd_ok) begin
                // Only reads are served while busy.
                unique case (opcode)
                    `SFHPS_OP_SET_LATCH: begin
                        if (arg_bytes == 3'h0) begin
                            status.write_enable_latch <= 1'b1;
                        end
                    end
                    `SFHPS_OP_CLR_LATCH: begin
                        status.write_enable_latch <= 1'b0;
                        status.auto_increment_program <= 1'b0;
                    end
                    `SFHPS_OP_STAT_WRITE: begin
                        if (arg_bytes == 3'h1 && status_wr_ok) begin
                            status <= (status & ~`SFHPS_STATUS_WMASK)
                                | (last_byte & `SFHPS_STATUS_WMASK);
                            status.write_enable_latch <= 1'b0;
                        end
                    end
                    `SFHPS_OP_BYTE_PROG, `SFHPS_OP_SECT_ERASE,
                        `SFHPS_OP_BLK_ERASE: begin
                        if (wel_ok && arg_bytes != 3'h0) begin
                            status.busy <= 1'b1;
                            op_timer <= op_len;
                            op_clears_wel <= 1'b1;
                        end
                    end
                    `SFHPS_OP_AUTO_PROG: begin
                        if (wel_ok && arg_bytes != 3'h0) begin
                            status.auto_increment_program <= 1'b1;
                            status.busy <= 1'b1;
                            op_timer <= op_len;
                            op_clears_wel <= 1'b0;
                        end
                    end
                    `SFHPS_OP_CHIP_ERASE_A, `SFHPS_OP_CHIP_ERASE_B: begin
                        if (wel_ok && status.protect_level == 3'h0) begin
                            status.busy <= 1'b1;
                            op_timer <= op_len;
                            op_clears_wel <= 1'b1;
                        end
                    end
                    default: begin
                        status <= status;
                    end
                endcase
            end
            status.reserved <= 1'b0;
        end
    end

    // Serial output: status byte shifted out on falling clock edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_byte <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= !lk.chip_sel_n && !paused && phase == SFHPS_ARGS
                && opcode == `SFHPS_OP_STAT_READ;
            if (phase == SFHPS_ARGS && bit_cnt == 3'h0 && sck_rise == 1'b0
                && opcode == `SFHPS_OP_STAT_READ && out_byte == 8'h00
                && sck_fall) begin
                out_byte <= {status[6:0], 1'b0};
                sdo <= status[7];
            end else if (sck_fall && opcode == `SFHPS_OP_STAT_READ) begin
                sdo <= (bit_cnt == 3'h0) ? status[7] : out_byte[7];
                out_byte <= (bit_cnt == 3'h0) ? {status[6:0], 1'b0}
                    : {out_byte[6:0], 1'b0};
            end
            if (frame_end) begin
                out_byte <= 8'h00;
            end
        end
    end

    // Region output follows the protection level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_from_block <= 5'h00;
        end else begin
            protect_from_block <= region_start(status.protect_level);
        end
    end

    // Counts completed commands for software to observe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_count <= 8'h00;
        end else if (cmd_ok) begin
            cmd_count <= cmd_count + 8'h01;
        end
    end

    // APB writes: control and operation length.
    logic apb_acc;
    assign apb_acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_len <= `SFHPS_OP_CYCLES_DEF;
            top_reached <= 1'b0;
        end else if (apb_acc && pwrite) begin
            if (paddr == `SFHPS_OFF_CTRL) begin
                top_reached <= pwdata[`SFHPS_CTRL_TOP_REACHED];
            end else if (paddr == `SFHPS_OFF_OPLEN) begin
                op_len <= pwdata[15:0];
            end
        end
    end

    // APB reads answer in the access cycle; unmapped gives an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                unique case (paddr)
                    `SFHPS_OFF_STATUS: prdata <= {`SFHPS_ZERO24, status};
                    `SFHPS_OFF_CTRL: prdata <= {31'h0, top_reached};
                    `SFHPS_OFF_LINK: prdata <= {16'h0000, cmd_count,
                        2'h0, paused, lk};
                    `SFHPS_OFF_OPLEN: prdata <= {16'h0000, op_len};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule : sfhps_core

`default_nettype wire

/* File: sfhps_consts.svh */
/*
 * Constants of the serial flash pause and status block: register offsets,
 * status bit positions, reset values, opcodes and timing counts.
 * Assumes it is included by bare name from design files of this block.
 */
`ifndef SFHPS_CONSTS_SVH
`define SFHPS_CONSTS_SVH

// Register byte offsets on the APB bus.
`define SFHPS_OFF_STATUS 12'h000
`define SFHPS_OFF_CTRL 12'h004
`define SFHPS_OFF_LINK 12'h008
`define SFHPS_OFF_OPLEN 12'h00C

// Status register bit positions.
`define SFHPS_BIT_BUSY 0
`define SFHPS_BIT_LATCH 1
`define SFHPS_BIT_LEVEL_LO 2
`define SFHPS_BIT_LEVEL_HI 4
`define SFHPS_BIT_AUTO_INC 6
`define SFHPS_BIT_LOCK 7

// Power-up value of the status register: protection level all ones.
`define SFHPS_STATUS_RESET 8'h1C
// Bits a status write may change: protection level and lock.
`define SFHPS_STATUS_WMASK 8'h9C

// Command opcodes seen on the serial input.
`define SFHPS_OP_SET_LATCH 8'h06
`define SFHPS_OP_CLR_LATCH 8'h04
`define SFHPS_OP_STAT_READ 8'h05
`define SFHPS_OP_STAT_WRITE 8'h01
`define SFHPS_OP_STAT_UNLOCK 8'h50
`define SFHPS_OP_BYTE_PROG 8'h02
`define SFHPS_OP_SECT_ERASE 8'h20
`define SFHPS_OP_BLK_ERASE 8'hD8
`define SFHPS_OP_CHIP_ERASE_A 8'h60
`define SFHPS_OP_CHIP_ERASE_B 8'hC7
`define SFHPS_OP_AUTO_PROG 8'hAD

// Default length of an internal program or erase, in pclk cycles.
`define SFHPS_OP_CYCLES_DEF 16'h0040
// Control register bits.
`define SFHPS_CTRL_TOP_REACHED 0
`define SFHPS_ZERO24 24'h000000
// Idle levels of the synchronised pins: select, pause and protect high.
`define SFHPS_LINK_IDLE 5'h13

`endif

/* File: sfhps_pkg.sv */
/*
 * Types of the serial flash pause and status block.
 * Assumes sfhps_consts.svh supplies the numeric constants.
 */
`default_nettype none

package sfhps_pkg;

    // Serial command decoder phase.
    typedef enum logic [1:0] {
        SFHPS_IDLE,
        SFHPS_OPCODE,
        SFHPS_ARGS,
        SFHPS_DONE
    } sfhps_phase_type;

    // Status register viewed as named fields.
    typedef struct packed {
        logic lock;
        logic auto_increment_program;
        logic reserved;
        logic [2:0] protect_level;
        logic write_enable_latch;
        logic busy;
    } sfhps_status_type;

    // Synchronised serial pins from the link.
    typedef struct packed {
        logic chip_sel_n;
        logic sclk;
        logic sdi;
        logic pause_n;
        logic wprot_n;
    } sfhps_link_type;

endpackage : sfhps_pkg

`default_nettype wire

/* File: sfhps_sync.sv */
/*
 * Two-stage synchroniser for the serial pins of the flash link.
 * Assumes the pins change freely relative to pclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sfhps_consts.svh"

module sfhps_sync
    import sfhps_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins and their synchronised copy.
    input wire sfhps_link_type pins,
    output sfhps_link_type synced
);

    // First stage, read only by the second stage.
    sfhps_link_type meta;

    // Idle levels: chip select, pause and write protect high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= `SFHPS_LINK_IDLE;
            synced <= `SFHPS_LINK_IDLE;
        end else begin
            meta <= pins;
            synced <= meta;
        end
    end

endmodule : sfhps_sync

`default_nettype wire

/* File: sfhps_core_asserts.sv */
/* Port checker of sfhps_core.
   Assumes a bind from the bench and status at offset zero. */
`timescale 1ns/100ps
`default_nettype none

module sfhps_core_asserts (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial side.
    input wire logic chip_sel_n,
    input wire logic sclk,
    input wire logic pause_n,
    input wire logic sdo_oe,
    input wire logic [4:0] protect_from_block
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A finished status read.
    sequence stat_rd;
        pready && !pwrite && paddr == 12'h000;
    endsequence
    // Pause held with select low and clock low, long enough to settle.
    sequence held_low;
        (!pause_n && !sclk && !chip_sel_n) [*4];
    endsequence
    // Select high long enough to settle.
    sequence deselected;
        chip_sel_n [*5];
    endsequence

    chk_apb_answer: assert property (psel && penable |-> pready)
        else $error("no answer in access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("answer held too long");
    chk_err_unmapped: assert property (pready && paddr > 12'h00C |->
        pslverr) else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && paddr[1:0] == 2'h0 &&
        paddr <= 12'h00C |-> !pslverr)
        else $error("mapped access refused");
    chk_stat_reserved: assert property (stat_rd |->
        prdata[31:8] == 24'h000000 && !prdata[5])
        else $error("reserved status bits set");
    chk_protect_map: assert property (stat_rd |->
        protect_from_block == (prdata[4:2] == 3'h0 ? 5'h10 :
        prdata[4:2] > 3'h4 ? 5'h00 :
        5'h10 - (5'h01 << (prdata[4:2] - 3'h1))))
        else $error("protected region wrong");
    chk_pause_float: assert property (held_low |=> !sdo_oe)
        else $error("output driven while paused");
    chk_idle_float: assert property (deselected |=> !sdo_oe)
        else $error("output driven while deselected");
endmodule : sfhps_core_asserts

`default_nettype wire

/* File: sfhps_host_model.sv */
/* SPI host model in mode 0 for the flash link.
   Assumes pclk paces it; the link clock is 8 pclk per period. */
`timescale 1ns/100ps
`default_nettype none

module sfhps_host_model (
    // Pacing clock.
    input wire logic pclk,
    // Pins toward the device.
    output logic chip_sel_n,
    output logic sclk,
    output logic sdi,
    output logic pause_n,
    output logic wprot_n,
    // Answer from the device.
    input wire logic sdo,
    input wire logic sdo_oe
);
    // Idle link: deselected, clock parked low.
    initial begin
        chip_sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        pause_n = 1'b1;
        wprot_n = 1'b1;
    end

    // Waits whole pclk cycles.
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // Sets the write-protect pin.
    task automatic set_wp(input logic v);
        wprot_n <= v;
        tick(2);
    endtask : set_wp

    // Sends n bytes MSB first; rd keeps the last byte seen on sdo.
    task automatic frame(input logic [39:0] d, input int n,
        input int hold, input bit abort, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        chip_sel_n <= 1'b0;
        tick(4);
        for (i = n * 8 - 1; i >= 0; i--) begin
            // pause only with select low and clock low.
            if (i == hold) begin
                pause_n <= 1'b0;
                tick(4);
                // Garbage edges that a paused device must not see.
                repeat (2) begin
                    sclk <= 1'b1;
                    sdi <= ~sdi;
                    tick(4);
                    sclk <= 1'b0;
                    tick(4);
                end
                if (abort) begin
                    chip_sel_n <= 1'b1;
                    tick(8);
                    pause_n <= 1'b1;
                    tick(8);
                    return;
                end
                // resume with pause high, select low.
                pause_n <= 1'b1;
                tick(4);
            end
            sdi <= d[i];
            tick(4);
            sclk <= 1'b1;
            // A floating output must never pass as data.
            rd = {rd[6:0], sdo_oe ? sdo : 1'bz};
            tick(4);
            sclk <= 1'b0;
        end
        tick(4);
        chip_sel_n <= 1'b1;
        // Released data line shows the inverse of its last value.
        sdi <= ~sdi;
        tick(8);
    endtask : frame
endmodule : sfhps_host_model

`default_nettype wire

/* File: test_serial_flash_hold_protect_status.sv */
/* Self-checking bench of sfhps_core with an SPI host model.
   Assumes status at 0x000 and OPLEN at 0x00C. */
`timescale 1ns/100ps
`default_nettype none

module test_serial_flash_hold_protect_status;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic chip_sel_n, sclk, sdi, pause_n, wprot_n, sdo, sdo_oe, er;
    logic [4:0] protect_from_block;
    logic [7:0] srd;
    logic [39:0] v;
    int fails = 0;
    int compares = 0;
    int st; // Expected status byte.
    int lv;
    int ops[5] = '{8'h02, 8'h20, 8'hD8, 8'h60, 8'hC7};
    int lens[5] = '{5, 4, 4, 1, 1};

    sfhps_core u_sfhps_core (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .chip_sel_n, .sclk,
        .sdi, .pause_n, .wprot_n, .sdo, .sdo_oe, .protect_from_block);
    sfhps_host_model u_sfhps_host_model (.pclk, .chip_sel_n, .sclk, .sdi,
        .pause_n, .wprot_n, .sdo, .sdo_oe);

    always #50 pclk = ~pclk;

    // Verdict and end of run.
    task automatic results();
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic cmp_reg(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_reg

    task automatic cmp_ser(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_ser

    // One APB transfer; waits for pready under a bound.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rq, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rq = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            results();
        end
    endtask : apb

    // Reads status and checks it with the protected region.
    task automatic rstat();
        int l;
        apb(1'b0, 12'h000, 32'h0, q, er);
        cmp_reg("status", st, q);
        l = (st >> 2) & 7;
        cmp_reg("region", l == 0 ? 16 : l > 4 ? 0 : 16 - (1 << (l - 1)),
            {27'h0, protect_from_block});
    endtask : rstat

    task automatic cmd(input logic [39:0] d, input int n,
        input int hold = -1, input bit abort = 1'b0);
        u_sfhps_host_model.frame(d, n, hold, abort, srd);
    endtask : cmd

    // Polls status until busy drops; running out of polls is a failure.
    task automatic idle();
        int n;
        for (n = 0; n < 200 && q[0] !== 1'b0; n++) begin
            apb(1'b0, 12'h000, 32'h0, q, er);
        end
        if (n == 200) begin
            fails++;
            results();
        end
    endtask : idle

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(32'hDB64));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        st = 8'h1C;
        rstat();
        apb(1'b0, 12'h008, 32'h0, q, er);
        cmp_reg("link", 32'h13, q);
        apb(1'b1, 12'h010, 32'h0, q, er);
        cmp_reg("slverr", 1, er);
        apb(1'b1, 12'h000, 32'hFF, q, er);
        rstat();
        apb(1'b1, 12'h00C, 32'h100, q, er);
        cmd(8'h06, 1);
        st = 8'h1E;
        rstat();
        cmd(8'h04, 1);
        st = 8'h1C;
        rstat();
        cmd({8'h02, 32'h0}, 5);
        rstat();
        // Every level, random junk in bits a write may not touch.
        for (lv = 7; lv >= 0; lv--) begin
            cmd(8'h06, 1);
            cmd(16'h0100 | (lv << 2) | ($urandom & 8'h63), 2);
            st = lv << 2;
            rstat();
            if (lv != 0) begin
                cmd(8'h06, 1);
                cmd(8'h60, 1);
                st = st | 2;
                rstat();
                cmd(8'h04, 1);
            end
        end
        // Each byte program and erase command at level zero.
        foreach (ops[i]) begin
            cmd(8'h06, 1);
            v = {8'h0, $urandom} & ((40'h1 << 8 * (lens[i] - 1)) - 1);
            cmd(v | (40'(ops[i]) << 8 * (lens[i] - 1)), lens[i]);
            st = 3;
            rstat();
            cmd(16'h0500, 2);
            cmp_ser("busy read", 3, srd);
            idle();
            st = 0;
            rstat();
        end
        // Auto-increment programming that reaches the top address.
        apb(1'b1, 12'h004, 32'h1, q, er);
        apb(1'b0, 12'h004, 32'h0, q, er);
        cmp_reg("ctrl", 1, q);
        cmd(8'h06, 1);
        cmd({8'hAD, $urandom}, 5);
        st = 8'h43;
        rstat();
        idle();
        st = 0;
        rstat();
        cmd(8'h06, 1);
        cmd(16'h0184, 2);
        st = 8'h84;
        rstat();
        u_sfhps_host_model.set_wp(1'b0);
        cmd(8'h06, 1);
        cmd(16'h0100, 2);
        st = 8'h86;
        rstat();
        u_sfhps_host_model.set_wp(1'b1);
        cmd(16'h0100, 2);
        st = 0;
        rstat();
        cmd(8'h06, 1, 3);
        st = 2;
        rstat();
        cmd(16'h0400, 2, 7, 1'b1);
        rstat();
        cmd(16'h0500, 2, 12);
        cmp_ser("paused read", 2, srd);
        results();
    end
endmodule : test_serial_flash_hold_protect_status

bind sfhps_core sfhps_core_asserts u_sfhps_core_asserts (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .chip_sel_n, .sclk, .pause_n, .sdo_oe, .protect_from_block);

`default_nettype wire
